// ---- rtl/hgcg_defs.svh ----
// register offsets, field positions and reset values of the guest csr group
`ifndef HGCG_DEFS_SVH
`define HGCG_DEFS_SVH
`define HGCG_OFF_PEND_LO 8'h00
`define HGCG_OFF_PEND_HI 8'h04
`define HGCG_OFF_EN_LO 8'h08
`define HGCG_OFF_EN_HI 8'h0C
`define HGCG_OFF_CFG_LO 8'h10
`define HGCG_OFF_CFG_HI 8'h14
`define HGCG_OFF_CNT 8'h18
`define HGCG_OFF_DELTA_LO 8'h1C
`define HGCG_OFF_DELTA_HI 8'h20
`define HGCG_OFF_CTRL 8'h24
`define HGCG_OFF_STAT 8'h28
`define HGCG_CFG_FENCE_BIT 0
`define HGCG_CFG_PBMT_HI_BIT 30
`define HGCG_CTRL_SEL_W 6
`define HGCG_STAT_SUPERVISOR_GUEST_IRQ_PENDING_BIT 0
`define HGCG_STAT_VIRTUAL_SUP_EXT_IRQ_PENDING_BIT 1
`define HGCG_RST_WORD 32'h0000_0000
`define HGCG_RESP_OKAY 2'h0
`define HGCG_RESP_SLVERR 2'h2
`endif

// ---- rtl/hgcg_pkg.sv ----
// types shared by the guest csr group
package hgcg_pkg;
  typedef logic [63:0] hgcg_dword_t;
  typedef logic [31:0] hgcg_word_t;
  typedef enum logic [0:0] {HGCG_RD_IDLE, HGCG_RD_BUSY} hgcg_rd_state_t;
endpackage

// ---- rtl/hgcg_csr_group.sv ----
// guest interrupt, environment, counter-enable and time-offset registers
//
// What this block does
// - guest irq i sits at bit i; pending read-only
// - enable bits count:1 writable; rest read zero
// - positions contiguous from bit 1; count may be zero
// - count at most 31 or 63 per hart
// - enables pick pending bits for supervisor guest irq
// - enables never touch the virtual-supervisor external irq
// - supervisor guest pending equals any pending-and-enabled bit
// - selected pending bit ORed into virtual-supervisor pending
// - widening: device fence bits imply memory read/write
// - widening: ordered device atomics also order memory
// - page memtype enable gates guest first-stage types
// - unimplemented page memtypes: bit reads zero
// - config split low word and upper word
// - counter access register 32 bits, always present
// - cleared guest bit with machine bit set traps
// - set guest bit allows virtualized counter access
// - virtual user needs guest and supervisor bits
// - counter bits may be hardwired zero, read-legal
// - virtualized time read adds guest offset
// - time sum drops carry out
// - time offset split low and upper words
//
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`include "hgcg_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module hgcg_csr_group #(
  parameter int XLEN = 64, // hypervisor register width
  parameter int GUEST_IRQ_COUNT = 8, // implemented guest irq count
  parameter bit PBMT_IMPL = 1'b1, // page memory types implemented
  parameter logic [31:0] CNT_IMPL_MASK = 32'hFFFF_FFFF // writable counter bits
) (
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, active low
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire hgcg_pkg::hgcg_dword_t guest_irq_pending_in, // controller levels
  input wire logic virt_mode, // hart runs virtualized
  input wire logic virtual_user_mode, // hart in virtual user mode
  input wire logic hvip_virtual_sup_ext_irq_pending_in, // software-injected vs external irq
  input wire logic platform_virtual_sup_ext_irq_pending_in, // other vs external sources
  output logic supervisor_guest_irq_pending, // to hart
  output logic virtual_sup_ext_irq_pending, // to hart
  input wire logic [3:0] fence_dev_in, // {pi,po,si,so}
  input wire logic [3:0] fence_mem_in, // {pr,pw,sr,sw}
  output logic [3:0] fence_mem_out, // effective {pr,pw,sr,sw}
  input wire logic amo_dev_in, // atomic targets device i/o
  input wire logic amo_aqrl_in, // atomic has aq or rl
  output logic amo_mem_order_out, // atomic also orders memory
  output logic page_memtype_active, // guest first-stage honours types
  input wire hgcg_pkg::hgcg_dword_t time_in, // real time value
  output hgcg_pkg::hgcg_dword_t guest_time_out, // time seen by reads
  input wire logic cnt_rd_valid, // counter read attempt
  input wire logic [4:0] cnt_rd_idx, // counter number
  input wire logic [31:0] mach_cnt_en, // machine counter enables
  input wire logic [31:0] sup_cnt_en, // supervisor counter enables
  output logic cnt_rd_ok, // read permitted here
  output logic cnt_rd_virt_exc // virtual instruction exception
);
  import hgcg_pkg::*;
  // byte-lane merge used by every writable word
  function automatic hgcg_word_t merge(input hgcg_word_t old_v, input hgcg_word_t new_v,
                                       input logic [3:0] strb);
    hgcg_word_t res;
    res = old_v;
    for (int b = 0; b < 4; b++)
      if (strb[b])
        res[b*8 +: 8] = new_v[b*8 +: 8];
    return res;
  endfunction
  // address decode shared by read and write paths
  function automatic logic mapped(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= `HGCG_OFF_STAT);
  endfunction
  // implemented guest irq positions: count down to 1, bit 0 never
  wire hgcg_dword_t irq_mask;
  genvar gi;
  generate
    for (gi = 0; gi < 64; gi++)
    begin : g_mask
      assign irq_mask[gi] = (gi >= 1) && (gi <= GUEST_IRQ_COUNT)
                            && (gi < XLEN);
    end
  endgenerate
  // register state
  hgcg_word_t en_lo_r, en_hi_r, cnt_r, delta_lo_r, delta_hi_r;
  hgcg_word_t en_lo_nxt, en_hi_nxt, cnt_nxt, delta_lo_nxt, delta_hi_nxt;
  logic fence_r, page_memtype_enable_r, fence_nxt, page_memtype_enable_nxt;
  logic [`HGCG_CTRL_SEL_W-1:0] sel_r, sel_nxt;
  logic aw_have_r, w_have_r, awready_r, wready_r, bvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [7:0] awaddr_r;
  hgcg_word_t wdata_r, rdata_r;
  logic [3:0] wstrb_r;
  hgcg_rd_state_t rd_state_r;
  logic arready_r, supervisor_guest_irq_pending_r, virtual_sup_ext_irq_pending_r, amo_r, pbmt_act_r, ok_r, exc_r;
  logic [3:0] fence_out_r;
  hgcg_dword_t gtime_r;
  // live views of the vectors
  hgcg_dword_t pend_v, en_v, delta_v;
  assign pend_v = guest_irq_pending_in & irq_mask;
  assign en_v = {en_hi_r, en_lo_r};
  assign delta_v = {delta_hi_r, delta_lo_r};
  // write commit happens once address and data are both held
  logic do_wr, wr_ok;
  assign do_wr = aw_have_r && w_have_r && !bvalid_r;
  assign wr_ok = mapped(awaddr_r) && (awaddr_r != `HGCG_OFF_PEND_LO)
                 && (awaddr_r != `HGCG_OFF_PEND_HI) && (awaddr_r != `HGCG_OFF_STAT);
  logic wr_en_lo, wr_en_hi, wr_cfg_lo, wr_cfg_hi, wr_cnt, wr_d_lo, wr_d_hi, wr_ctrl;
  assign wr_en_lo = do_wr && (awaddr_r == `HGCG_OFF_EN_LO);
  assign wr_en_hi = do_wr && (awaddr_r == `HGCG_OFF_EN_HI);
  assign wr_cfg_lo = do_wr && (awaddr_r == `HGCG_OFF_CFG_LO);
  assign wr_cfg_hi = do_wr && (awaddr_r == `HGCG_OFF_CFG_HI);
  assign wr_cnt = do_wr && (awaddr_r == `HGCG_OFF_CNT);
  assign wr_d_lo = do_wr && (awaddr_r == `HGCG_OFF_DELTA_LO);
  assign wr_d_hi = do_wr && (awaddr_r == `HGCG_OFF_DELTA_HI);
  assign wr_ctrl = do_wr && (awaddr_r == `HGCG_OFF_CTRL);

  // next values; illegal bits are dropped so reads stay legal
  hgcg_word_t m_en_lo, m_en_hi, m_cfg_lo, m_cfg_hi, m_cnt, m_ctrl;
  assign m_en_lo = merge(en_lo_r, wdata_r, wstrb_r);
  assign m_en_hi = merge(en_hi_r, wdata_r, wstrb_r);
  assign m_cfg_lo = merge({31'h0000_0000, fence_r}, wdata_r, wstrb_r);
  assign m_cfg_hi = merge({1'b0, page_memtype_enable_r, 30'h0000_0000}, wdata_r, wstrb_r);
  assign m_cnt = merge(cnt_r, wdata_r, wstrb_r);
  assign m_ctrl = merge({26'h000_0000, sel_r}, wdata_r, wstrb_r);
  assign en_lo_nxt = wr_en_lo ? (m_en_lo & irq_mask[31:0]) : en_lo_r;
  assign en_hi_nxt = wr_en_hi ? (m_en_hi & irq_mask[63:32]) : en_hi_r;
  assign fence_nxt = wr_cfg_lo ? m_cfg_lo[`HGCG_CFG_FENCE_BIT] : fence_r;
  assign page_memtype_enable_nxt = wr_cfg_hi ? (m_cfg_hi[`HGCG_CFG_PBMT_HI_BIT] & PBMT_IMPL)
                               : page_memtype_enable_r;
  assign cnt_nxt = wr_cnt ? (m_cnt & CNT_IMPL_MASK) : cnt_r;
  assign delta_lo_nxt = wr_d_lo ? merge(delta_lo_r, wdata_r, wstrb_r) : delta_lo_r;
  assign delta_hi_nxt = wr_d_hi ? merge(delta_hi_r, wdata_r, wstrb_r) : delta_hi_r;
  assign sel_nxt = wr_ctrl ? m_ctrl[`HGCG_CTRL_SEL_W-1:0] : sel_r;
  // read data mux
  hgcg_word_t rd_mux;
  always_comb
  begin
    case (s_axi_araddr)
      `HGCG_OFF_PEND_LO: rd_mux = pend_v[31:0];
      `HGCG_OFF_PEND_HI: rd_mux = pend_v[63:32];
      `HGCG_OFF_EN_LO: rd_mux = en_lo_r;
      `HGCG_OFF_EN_HI: rd_mux = en_hi_r;
      `HGCG_OFF_CFG_LO: rd_mux = {31'h0000_0000, fence_r};
      `HGCG_OFF_CFG_HI: rd_mux = {1'b0, page_memtype_enable_r, 30'h0000_0000};
      `HGCG_OFF_CNT: rd_mux = cnt_r;
      `HGCG_OFF_DELTA_LO: rd_mux = delta_lo_r;
      `HGCG_OFF_DELTA_HI: rd_mux = delta_hi_r;
      `HGCG_OFF_CTRL: rd_mux = {26'h000_0000, sel_r};
      `HGCG_OFF_STAT: rd_mux = {30'h0000_0000, virtual_sup_ext_irq_pending_r, supervisor_guest_irq_pending_r};
      default: rd_mux = `HGCG_RST_WORD;
    endcase
  end
  // hart-facing results
  logic supervisor_guest_irq_pending_nxt, virtual_sup_ext_irq_pending_nxt, amo_nxt, ok_nxt, exc_nxt, h_bit, m_bit, s_bit;
  logic [3:0] fence_nxt_out;
  assign supervisor_guest_irq_pending_nxt = |(pend_v & en_v);
  assign virtual_sup_ext_irq_pending_nxt = pend_v[sel_r] | hvip_virtual_sup_ext_irq_pending_in | platform_virtual_sup_ext_irq_pending_in;
  assign fence_nxt_out = fence_mem_in | ((fence_r && virt_mode) ? fence_dev_in : 4'h0);
  assign amo_nxt = fence_r && virt_mode && amo_dev_in && amo_aqrl_in;
  assign h_bit = cnt_r[cnt_rd_idx];
  assign m_bit = mach_cnt_en[cnt_rd_idx];
  assign s_bit = sup_cnt_en[cnt_rd_idx];
  assign exc_nxt = cnt_rd_valid && virt_mode && m_bit
                   && (!h_bit || (virtual_user_mode && !s_bit));
  assign ok_nxt = cnt_rd_valid && m_bit
                  && (!virt_mode || (h_bit && (!virtual_user_mode || s_bit)));
  // register updates
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      en_lo_r <= `HGCG_RST_WORD;
      en_hi_r <= `HGCG_RST_WORD;
      cnt_r <= `HGCG_RST_WORD;
      delta_lo_r <= `HGCG_RST_WORD;
      delta_hi_r <= `HGCG_RST_WORD;
      fence_r <= 1'b0;
      page_memtype_enable_r <= 1'b0;
      sel_r <= '0;
    end
    else
    begin
      en_lo_r <= en_lo_nxt;
      en_hi_r <= en_hi_nxt;
      cnt_r <= cnt_nxt;
      delta_lo_r <= delta_lo_nxt;
      delta_hi_r <= delta_hi_nxt;
      fence_r <= fence_nxt;
      page_memtype_enable_r <= page_memtype_enable_nxt;
      sel_r <= sel_nxt;
    end
  end

  // axi write channel: address and data in either order, then response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= `HGCG_RESP_OKAY;
      awaddr_r <= 8'h00;
      wdata_r <= `HGCG_RST_WORD;
      wstrb_r <= 4'h0;
    end
    else
    begin
      if (awready_r && s_axi_awvalid)
      begin
        aw_have_r <= 1'b1;
        awready_r <= 1'b0;
        awaddr_r <= s_axi_awaddr;
      end
      if (wready_r && s_axi_wvalid)
      begin
        w_have_r <= 1'b1;
        wready_r <= 1'b0;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (do_wr)
      begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_ok ? `HGCG_RESP_OKAY : `HGCG_RESP_SLVERR;
      end
      if (bvalid_r && s_axi_bready)
      begin
        bvalid_r <= 1'b0;
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end

  // axi read channel: one read in flight
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rd_state_r <= HGCG_RD_IDLE;
      arready_r <= 1'b1;
      rdata_r <= `HGCG_RST_WORD;
      rresp_r <= `HGCG_RESP_OKAY;
    end
    else
    begin
      case (rd_state_r)
        HGCG_RD_IDLE:
        begin
          if (s_axi_arvalid)
          begin
            rd_state_r <= HGCG_RD_BUSY;
            arready_r <= 1'b0;
            rdata_r <= rd_mux;
            rresp_r <= mapped(s_axi_araddr) ? `HGCG_RESP_OKAY : `HGCG_RESP_SLVERR;
          end
        end
        HGCG_RD_BUSY:
        begin
          if (s_axi_rready)
          begin
            rd_state_r <= HGCG_RD_IDLE;
            arready_r <= 1'b1;
          end
        end
        default:
        begin
          rd_state_r <= HGCG_RD_IDLE;
          arready_r <= 1'b1;
        end
      endcase
    end
  end

  // hart-facing outputs, registered
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      supervisor_guest_irq_pending_r <= 1'b0;
      virtual_sup_ext_irq_pending_r <= 1'b0;
      fence_out_r <= 4'h0;
      amo_r <= 1'b0;
      pbmt_act_r <= 1'b0;
      gtime_r <= 64'h0000_0000_0000_0000;
      ok_r <= 1'b0;
      exc_r <= 1'b0;
    end
    else
    begin
      supervisor_guest_irq_pending_r <= supervisor_guest_irq_pending_nxt;
      virtual_sup_ext_irq_pending_r <= virtual_sup_ext_irq_pending_nxt;
      fence_out_r <= fence_nxt_out;
      amo_r <= amo_nxt;
      pbmt_act_r <= page_memtype_enable_r;
      gtime_r <= virt_mode ? (time_in + delta_v) : time_in;
      ok_r <= ok_nxt;
      exc_r <= exc_nxt;
    end
  end
  // outputs taken straight from their flops
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = (rd_state_r == HGCG_RD_BUSY);
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign supervisor_guest_irq_pending = supervisor_guest_irq_pending_r;
  assign virtual_sup_ext_irq_pending = virtual_sup_ext_irq_pending_r;
  assign fence_mem_out = fence_out_r;
  assign amo_mem_order_out = amo_r;
  assign page_memtype_active = pbmt_act_r;
  assign guest_time_out = gtime_r;
  assign cnt_rd_ok = ok_r;
  assign cnt_rd_virt_exc = exc_r;
  // checks on the block's own behaviour
  property p_count_lim;
    @(posedge aclk) disable iff (!aresetn) GUEST_IRQ_COUNT <= XLEN - 1;
  endproperty
  a_count_lim: assert property (p_count_lim) else $error("guest irq count too large");
  property p_en_legal;
    @(posedge aclk) disable iff (!aresetn) ##1 (en_v & ~irq_mask) == 64'h0;
  endproperty
  a_en_legal: assert property (p_en_legal) else $error("enable bit outside range");
  property p_supervisor_guest_irq_pending;
    @(posedge aclk) disable iff (!aresetn)
      (|(guest_irq_pending_in & irq_mask & en_v)) |=> supervisor_guest_irq_pending;
  endproperty
  a_supervisor_guest_irq_pending: assert property (p_supervisor_guest_irq_pending) else $error("guest irq not summarised");
  property p_virtual_sup_ext_irq_pending;
    @(posedge aclk) disable iff (!aresetn)
      (pend_v[sel_r] && !hvip_virtual_sup_ext_irq_pending_in && !platform_virtual_sup_ext_irq_pending_in) |=> virtual_sup_ext_irq_pending;
  endproperty
  a_virtual_sup_ext_irq_pending: assert property (p_virtual_sup_ext_irq_pending) else $error("selected guest irq lost");
  property p_fence;
    @(posedge aclk) disable iff (!aresetn)
      (fence_r && virt_mode && fence_dev_in[3]) |=> fence_mem_out[3];
  endproperty
  a_fence: assert property (p_fence) else $error("fence not widened");
  property p_amo;
    @(posedge aclk) disable iff (!aresetn)
      (!virt_mode || !fence_r) |=> !amo_mem_order_out;
  endproperty
  a_amo: assert property (p_amo) else $error("atomic widened outside guest");
  property p_pbmt;
    @(posedge aclk) disable iff (!aresetn)
      ##1 page_memtype_active == ($past(page_memtype_enable_r) && PBMT_IMPL);
  endproperty
  a_pbmt: assert property (p_pbmt) else $error("page type state wrong");
  property p_time;
    @(posedge aclk) disable iff (!aresetn)
      virt_mode |=> guest_time_out == $past(time_in) + $past(delta_v);
  endproperty
  a_time: assert property (p_time) else $error("guest time wrong");
  property p_cnt_exc;
    @(posedge aclk) disable iff (!aresetn)
      (cnt_rd_valid && virt_mode && m_bit && !h_bit) |=> cnt_rd_virt_exc && !cnt_rd_ok;
  endproperty
  a_cnt_exc: assert property (p_cnt_exc) else $error("missing virtual exception");
  property p_vu;
    @(posedge aclk) disable iff (!aresetn)
      (cnt_rd_valid && virt_mode && virtual_user_mode && !s_bit) |=> !cnt_rd_ok;
  endproperty
  a_vu: assert property (p_vu) else $error("user read without both bits");
  property p_bhold;
    @(posedge aclk) disable iff (!aresetn)
      (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
endmodule // hgcg_csr_group
`default_nettype wire

// ---- tb/hgcg_irq_ctrl_model.sv ----
// interrupt controller model that drives the guest pending levels
`timescale 1ns/1ps
`default_nettype none
module hgcg_irq_ctrl_model (
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, active low
  input wire hgcg_pkg::hgcg_dword_t src_a, // first device source per virtual hart
  input wire hgcg_pkg::hgcg_dword_t src_b, // second device source per virtual hart
  output hgcg_pkg::hgcg_dword_t pend_o // per-virtual-hart summary levels
);
  import hgcg_pkg::*;
  // each level is the summary of every source aimed at one virtual hart
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pend_o <= '0;
    else
      pend_o <= src_a | src_b;
  end
endmodule // hgcg_irq_ctrl_model
`default_nettype wire

// ---- tb/hypervisor_guest_csr_group_tb.sv ----
// self-checking bench of the guest csr group
`timescale 1ns/1ps
`default_nettype none
`include "hgcg_defs.svh"
`define CHK(nm, ex, ac) begin check_count++; if ((ac) !== (ex)) begin miscompares++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, ex, ac); end end
module hypervisor_guest_csr_group_tb;
  import hgcg_pkg::*;
  localparam int GC = 8;
  localparam logic [63:0] GMASK = ((64'h1 << (GC + 1)) - 64'h1) & ~64'h1;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = '0, wstrb_v = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rd, hc;
  hgcg_dword_t guest_irq_pending_in, guest_time_out, en, off, p;
  hgcg_dword_t time_in = '0, src_a = '0, src_b = '0;
  logic virt_mode = 0, virtual_user_mode = 0, hvip_virtual_sup_ext_irq_pending_in = 0, platform_virtual_sup_ext_irq_pending_in = 0;
  logic supervisor_guest_irq_pending, virtual_sup_ext_irq_pending, amo_mem_order_out;
  logic page_memtype_active, cnt_rd_ok, cnt_rd_virt_exc, fw, pb, w;
  logic [3:0] fence_dev_in = '0, fence_mem_in = '0, fence_mem_out;
  logic amo_dev_in = 0, amo_aqrl_in = 0, cnt_rd_valid = 0;
  logic [4:0] cnt_rd_idx = '0;
  logic [31:0] mach_cnt_en = '0, sup_cnt_en = '0;
  logic [5:0] sel;
  int miscompares = 0;
  int check_count = 0;
  // free-running 250 MHz clock
  always #2 aclk = ~aclk;
  // device under test, eight guest irqs, other defaults kept
  hgcg_csr_group #(.GUEST_IRQ_COUNT(GC)) uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .guest_irq_pending_in, .virt_mode,
    .virtual_user_mode, .hvip_virtual_sup_ext_irq_pending_in, .platform_virtual_sup_ext_irq_pending_in, .supervisor_guest_irq_pending,
    .virtual_sup_ext_irq_pending, .fence_dev_in, .fence_mem_in, .fence_mem_out, .amo_dev_in,
    .amo_aqrl_in, .amo_mem_order_out, .page_memtype_active, .time_in, .guest_time_out,
    .cnt_rd_valid, .cnt_rd_idx, .mach_cnt_en, .sup_cnt_en, .cnt_rd_ok, .cnt_rd_virt_exc);
  // far-side interrupt controller
  hgcg_irq_ctrl_model ctrl (.aclk(aclk), .aresetn(aresetn), .src_a(src_a), .src_b(src_b),
    .pend_o(guest_irq_pending_in));
  // verdict and end of run
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // lets registered hart outputs follow the inputs
  task automatic settle;
    repeat (3) @(posedge aclk);
    #1;
  endtask
  // one write: address and data offered together, each dropped when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= wstrb_v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1)
      begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
      n++;
      if (n > 50)
      begin
        miscompares++;
        close_out();
      end
    end
  endtask
  // one read, data taken at the rvalid edge
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1)
      begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
      n++;
      if (n > 50)
      begin
        miscompares++;
        close_out();
      end
    end
  endtask
  // read a register and compare data and an okay response
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] ex);
    axi_rd(a, rd, resp);
    `CHK("rdata", ex, rd)
    `CHK("rresp", `HGCG_RESP_OKAY, resp)
  endtask
  // expected counter permission and trap
  function automatic logic exp_ok(logic m, logic h, logic s, logic v, logic vu);
    return m & (!v | (h & (!vu | s)));
  endfunction
  function automatic logic exp_exc(logic m, logic h, logic s, logic v, logic vu);
    return v & m & (!h | (vu & !s));
  endfunction
  // main sequence
  initial
  begin
    void'($urandom(32'h4423));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    for (int a = 0; a <= 'h28; a += 4) rd_chk(8'(a), 32'h0000_0000);
    axi_wr(`HGCG_OFF_EN_LO, 32'hFFFF_FFFF, resp);
    rd_chk(`HGCG_OFF_EN_LO, GMASK[31:0]);
    axi_wr(`HGCG_OFF_EN_HI, 32'hFFFF_FFFF, resp);
    rd_chk(`HGCG_OFF_EN_HI, GMASK[63:32]);
    src_a <= '1;
    settle();
    rd_chk(`HGCG_OFF_PEND_LO, GMASK[31:0]);
    rd_chk(`HGCG_OFF_PEND_LO, GMASK[31:0]);
    rd_chk(`HGCG_OFF_PEND_HI, GMASK[63:32]);
    axi_wr(`HGCG_OFF_PEND_LO, 32'h0000_0000, resp);
    `CHK("pend write resp", `HGCG_RESP_SLVERR, resp)
    rd_chk(`HGCG_OFF_PEND_LO, GMASK[31:0]);
    axi_rd(8'h30, rd, resp);
    `CHK("unmapped resp", `HGCG_RESP_SLVERR, resp)
    // enables and select against random pending summaries
    for (int i = 0; i < 24; i++)
    begin
      en = {32'h0000_0000, $urandom};
      sel = 6'($urandom_range(0, 15));
      axi_wr(`HGCG_OFF_EN_LO, en[31:0], resp);
      axi_wr(`HGCG_OFF_CTRL, {26'h0, sel}, resp);
      src_a <= {32'h0000_0000, $urandom & $urandom & $urandom};
      src_b <= {32'h0000_0000, $urandom & $urandom & $urandom};
      hvip_virtual_sup_ext_irq_pending_in <= ($urandom_range(0, 3) == 0);
      platform_virtual_sup_ext_irq_pending_in <= ($urandom_range(0, 3) == 0);
      settle();
      p = (src_a | src_b) & GMASK;
      `CHK("supervisor_guest_irq_pending", |(p & en), supervisor_guest_irq_pending)
      w = p[sel] | hvip_virtual_sup_ext_irq_pending_in | platform_virtual_sup_ext_irq_pending_in;
      `CHK("virtual_sup_ext_irq_pending", w, virtual_sup_ext_irq_pending)
      rd_chk(`HGCG_OFF_STAT, {30'h0, w, |(p & en)});
    end
    // fence widening, atomics and page memory types
    for (int i = 0; i < 16; i++)
    begin
      fw = $urandom_range(0, 1);
      pb = $urandom_range(0, 1);
      axi_wr(`HGCG_OFF_CFG_LO, {31'h0, fw}, resp);
      axi_wr(`HGCG_OFF_CFG_HI, {1'b0, pb, 30'h0}, resp);
      virt_mode <= $urandom_range(0, 1);
      fence_dev_in <= 4'($urandom);
      fence_mem_in <= 4'($urandom);
      amo_dev_in <= $urandom_range(0, 1);
      amo_aqrl_in <= $urandom_range(0, 1);
      settle();
      w = fw & virt_mode;
      `CHK("fence", w ? (fence_mem_in | fence_dev_in) : fence_mem_in, fence_mem_out)
      `CHK("amo", w & amo_dev_in & amo_aqrl_in, amo_mem_order_out)
      `CHK("pbmt", pb, page_memtype_active)
      rd_chk(`HGCG_OFF_CFG_LO, {31'h0, fw});
      rd_chk(`HGCG_OFF_CFG_HI, {1'b0, pb, 30'h0});
    end
    // counter permission over random enables and modes
    for (int i = 0; i < 32; i++)
    begin
      hc = (i == 0) ? 32'h0000_0000 : $urandom;
      axi_wr(`HGCG_OFF_CNT, hc, resp);
      rd_chk(`HGCG_OFF_CNT, hc);
      mach_cnt_en <= $urandom;
      sup_cnt_en <= $urandom;
      virt_mode <= $urandom_range(0, 1);
      virtual_user_mode <= $urandom_range(0, 1);
      cnt_rd_idx <= 5'($urandom);
      cnt_rd_valid <= 1'b1;
      settle();
      w = exp_ok(mach_cnt_en[cnt_rd_idx], hc[cnt_rd_idx], sup_cnt_en[cnt_rd_idx], virt_mode,
                 virtual_user_mode);
      `CHK("cnt ok", w, cnt_rd_ok)
      w = exp_exc(mach_cnt_en[cnt_rd_idx], hc[cnt_rd_idx], sup_cnt_en[cnt_rd_idx], virt_mode,
                  virtual_user_mode);
      `CHK("cnt exc", w, cnt_rd_virt_exc)
    end
    // guest time offset, carry dropped
    for (int i = 0; i < 8; i++)
    begin
      off = (i == 0) ? '1 : {$urandom, $urandom};
      axi_wr(`HGCG_OFF_DELTA_LO, off[31:0], resp);
      axi_wr(`HGCG_OFF_DELTA_HI, off[63:32], resp);
      rd_chk(`HGCG_OFF_DELTA_LO, off[31:0]);
      rd_chk(`HGCG_OFF_DELTA_HI, off[63:32]);
      time_in <= (i == 1) ? '1 : {$urandom, $urandom};
      virt_mode <= (i < 2) ? 1'b1 : 1'($urandom_range(0, 1));
      settle();
      `CHK("time", virt_mode ? time_in + off : time_in, guest_time_out)
    end
    // byte strobes: only the enabled lanes of the offset word change
    wstrb_v = 4'h5;
    axi_wr(`HGCG_OFF_DELTA_LO, 32'hA5A5_A5A5, resp);
    wstrb_v = 4'hF;
    rd_chk(`HGCG_OFF_DELTA_LO, (off[31:0] & 32'hFF00_FF00) | 32'h00A5_00A5);
    close_out();
  end
endmodule // hypervisor_guest_csr_group_tb
`default_nettype wire
